/* verilog/pfw_pkg.sv */
// Purpose: constants for the pin function and wake signal block
// Assumes: aclk at 125 MHz, flag bytes arrive once from the loader
// Notes: register map, flag fields and pulse timing
// Function
// - bit 7 picks second indicator role
// - role ignored unless pin 2 indicator
// - bits 6:2 pick indicator per pin
// - bit 1 widens power switch states
// - bit 0 sets power switch polarity
// - wake enable asserts wake on events
// - disabled wake ignores other wake bits
// - bit 6 picks level or pulse
// - bit 5 picks 1.5 or 150 ms
// - bit 4 sets wake level or pulse direction
// - bit 3 picks single-sided or push-pull
// - single-sided is drain or source by polarity
// - bit 2 picks network or link-up source
// - bits 1,0 enable magic and address wake
package pfw_pkg;
   localparam real         CLK_MHZ        = 125.0;
   localparam real         WAKE_SHORT_MS  = 1.5;
   localparam real         WAKE_LONG_MS   = 150.0;
   localparam int unsigned WAKE_SHORT_CYC = int'(WAKE_SHORT_MS * 1000.0 * CLK_MHZ);
   localparam int unsigned WAKE_LONG_CYC  = int'(WAKE_LONG_MS * 1000.0 * CLK_MHZ);
   localparam int          CNT_W          = 25;

   // first flag byte
   localparam int C1_ROLE   = 7;
   localparam int C1_IND_LO = 2;
   localparam int IND_W     = 5;
   localparam int PIN2      = 2;
   localparam int C1_SWSEL  = 1;
   localparam int C1_SWPOL  = 0;
   // wake flag byte
   localparam int WK_EN     = 7;
   localparam int WK_FORM   = 6;
   localparam int WK_LEN    = 5;
   localparam int WK_POL    = 4;
   localparam int WK_DRV    = 3;
   localparam int WK_CLASS  = 2;
   localparam int WK_MAGIC  = 1;
   localparam int WK_DA     = 0;
   localparam logic [7:0] CFG1_RST = 8'h00;
   localparam logic [7:0] WAKE_RST = 8'h00;

   // register map
   localparam int         ADDR_W     = 4;
   localparam logic [3:0] A_FLAGS    = 4'h0;
   localparam logic [3:0] A_STATUS   = 4'h4;
   localparam logic [3:0] A_MASK     = 4'h8;
   localparam logic [3:0] A_STATE    = 4'hC;
   localparam int         ST_W       = 4;
   localparam int         ST_PIN     = 0;
   localparam int         ST_MAGIC   = 1;
   localparam int         ST_DA      = 2;
   localparam int         ST_LINK    = 3;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVER = 2'h2;

   typedef enum logic {
      PS_IDLE = 1'b0,
      PS_BUSY = 1'b1
   } pfw_pulse_e;
endpackage : pfw_pkg

/* verilog/pfw_pulse_if.sv */
// Purpose: link between wake control and pulse timer
// Assumes: both ends on aclk
// Notes: start is a one-cycle request
`timescale 1ns/1ps
interface pfw_pulse_if;
   logic start;
   logic long_sel;
   logic busy;
   modport ctrl  (output start, output long_sel, input busy);
   modport timer (input start, input long_sel, output busy);
endinterface : pfw_pulse_if

/* verilog/pfw_pulse_timer.sv */
// Purpose: timed wake pulse of short or long length
// Assumes: start only taken while idle
// Notes: busy stands exactly the chosen count of cycles
`timescale 1ns/1ps
module pfw_pulse_timer #(
   parameter int unsigned SHORT_CYC = pfw_pkg::WAKE_SHORT_CYC,
   parameter int unsigned LONG_CYC  = pfw_pkg::WAKE_LONG_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   pfw_pulse_if.timer pif
);
   import pfw_pkg::*;

   pfw_pulse_e               state_ff;
   pfw_pulse_e               nxt_state;
   logic       [CNT_W-1:0]   cnt_ff;
   logic       [CNT_W-1:0]   nxt_cnt;
   wire        [CNT_W-1:0]   load_val = pif.long_sel ? CNT_W'(LONG_CYC - 1)
                                                     : CNT_W'(SHORT_CYC - 1);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         PS_IDLE: begin
            if (pif.start) begin
               nxt_state = PS_BUSY;
               nxt_cnt   = load_val;
            end
         end
         PS_BUSY: begin
            if (cnt_ff == '0) begin
               nxt_state = PS_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         default: nxt_state = PS_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= PS_IDLE;
         cnt_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   assign pif.busy = (state_ff == PS_BUSY);
endmodule : pfw_pulse_timer

/* verilog/pfw_top.sv */
// Purpose: pin function select, power switch pin and wake output
// Assumes: flag bytes from the loader on aclk, one wake pin async
// Notes: AXI4-Lite registers, status write-one-to-clear
`timescale 1ns/1ps
module pfw_top #(
   parameter int unsigned SHORT_CYC = pfw_pkg::WAKE_SHORT_CYC,
   parameter int unsigned LONG_CYC  = pfw_pkg::WAKE_LONG_CYC
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // axi4-lite slave
   input  wire logic [pfw_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   input  wire logic [pfw_pkg::ADDR_W-1:0] araddr,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   // flag bytes from the serial memory loader
   input  wire logic                      flags_valid,
   input  wire logic [7:0]                cfg1_in,
   input  wire logic [7:0]                wake_flags_in,
   // power states and wake sources
   input  wire logic                      light_suspend_state,
   input  wire logic                      deep_suspend_state,
   input  wire logic                      cable_detached,
   input  wire logic                      wake_pin_in,
   input  wire logic                      magic_pkt_evt,
   input  wire logic                      da_match_evt,
   input  wire logic                      link_up_evt,
   // pins
   output logic [pfw_pkg::IND_W-1:0]      pin_indicator_select,
   output logic                           second_indicator_role,
   output logic                           power_switch_control_pin,
   output logic                           wake_output_pin_o,
   output logic                           wake_output_pin_oe,
   output logic                           irq
);
   import pfw_pkg::*;

   pfw_pulse_if pif ();

   pfw_pulse_timer #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
   ) u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pif     (pif)
   );

   // flag bytes, latched once
   logic [7:0]      cfg1_ff;
   logic [7:0]      wk_ff;
   logic            loaded_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg1_ff   <= CFG1_RST;
         wk_ff     <= WAKE_RST;
         loaded_ff <= 1'b0;
      end else if (!loaded_ff && flags_valid) begin
         cfg1_ff   <= cfg1_in;
         wk_ff     <= wake_flags_in;
         loaded_ff <= 1'b1;
      end
   end

   // flag decode
   wire wk_en    = wk_ff[WK_EN];
   wire wk_form  = wk_ff[WK_FORM];
   wire wk_pol   = wk_ff[WK_POL];
   wire wk_drv   = wk_ff[WK_DRV];
   wire wk_class = wk_ff[WK_CLASS];

   // indicator and power switch pins
   // per-pin indicator select
   wire [IND_W-1:0] nxt_ind = cfg1_ff[C1_IND_LO +: IND_W];
   // role forced off unless pin 2 lit
   wire nxt_role = cfg1_ff[C1_ROLE] & nxt_ind[PIN2];
   wire sw_asrt  = deep_suspend_state |
                   (cfg1_ff[C1_SWSEL] & (light_suspend_state | cable_detached));
   wire nxt_sw   = cfg1_ff[C1_SWPOL] ? sw_asrt : ~sw_asrt;

   // wake pin synchroniser
   logic wp_s1_ff;
   logic wp_s2_ff;
   logic wp_s3_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_s1_ff <= 1'b0;
         wp_s2_ff <= 1'b0;
         wp_s3_ff <= 1'b0;
      end else begin
         wp_s1_ff <= wake_pin_in;
         wp_s2_ff <= wp_s1_ff;
         wp_s3_ff <= wp_s2_ff;
      end
   end
   wire pin_evt = wp_s2_ff & ~wp_s3_ff;

   wire [ST_W-1:0] qual;
   assign qual[ST_PIN]   = wk_en & pin_evt;
   assign qual[ST_MAGIC] = wk_en & ~wk_class & wk_ff[WK_MAGIC] & magic_pkt_evt;
   assign qual[ST_DA]    = wk_en & ~wk_class & wk_ff[WK_DA] & da_match_evt;
   assign qual[ST_LINK]  = wk_en & wk_class & link_up_evt;
   wire any_qual = |qual;

   // status, mask
   logic [ST_W-1:0] status_ff;
   logic [ST_W-1:0] mask_ff;
   logic [ST_W-1:0] st_clr;
   logic [ST_W-1:0] mask_wr;
   logic            mask_we;
   // set wins over clear
   wire  [ST_W-1:0] nxt_status = (status_ff & ~st_clr) | qual;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= '0;
         mask_ff   <= '0;
      end else begin
         status_ff <= nxt_status;
         if (mask_we) begin
            mask_ff <= mask_wr;
         end
      end
   end

   // one pulse per event, merged while busy
   logic start_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_ff <= 1'b0;
      end else begin
         start_ff <= wk_form & any_qual & ~pif.busy & ~start_ff;
      end
   end
   assign pif.start    = start_ff;
   assign pif.long_sel = wk_ff[WK_LEN];

   wire act = wk_en & (wk_form ? pif.busy : (|status_ff));
   wire nxt_wo  = wk_en & (wk_drv ? (act ~^ wk_pol) : wk_pol);
   wire nxt_woe = wk_en & (wk_drv | act);

   logic act_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_indicator_select     <= '0;
         second_indicator_role    <= 1'b0;
         power_switch_control_pin <= 1'b0;
         wake_output_pin_o        <= 1'b0;
         wake_output_pin_oe       <= 1'b0;
         act_ff                   <= 1'b0;
         irq                      <= 1'b0;
      end else begin
         pin_indicator_select     <= nxt_ind;
         second_indicator_role    <= nxt_role;
         power_switch_control_pin <= nxt_sw;
         wake_output_pin_o        <= nxt_wo;
         wake_output_pin_oe       <= nxt_woe;
         act_ff                   <= act;
         irq                      <= |(status_ff & mask_ff);
      end
   end

   // axi4-lite write side
   logic [ADDR_W-1:0] aw_addr_ff;
   logic              aw_got_ff;
   logic [31:0]       w_data_ff;
   logic [3:0]        w_strb_ff;
   logic              w_got_ff;
   wire aw_take = awvalid & awready;
   wire w_take  = wvalid & wready;
   wire wr_do   = aw_got_ff & w_got_ff & ~bvalid;
   wire wr_st   = wr_do & (aw_addr_ff == A_STATUS);
   wire wr_mk   = wr_do & (aw_addr_ff == A_MASK);
   wire wr_ok   = (aw_addr_ff == A_FLAGS) | (aw_addr_ff == A_STATUS) |
                  (aw_addr_ff == A_MASK)  | (aw_addr_ff == A_STATE);
   assign st_clr  = (wr_st & w_strb_ff[0]) ? w_data_ff[ST_W-1:0] : '0;
   assign mask_we = wr_mk & w_strb_ff[0];
   assign mask_wr = w_data_ff[ST_W-1:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff  <= 1'b0;
         w_got_ff   <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff  <= '0;
         w_strb_ff  <= '0;
         awready    <= 1'b0;
         wready     <= 1'b0;
         bvalid     <= 1'b0;
         bresp      <= RESP_OKAY;
      end else begin
         awready <= ~aw_got_ff & ~aw_take & ~wr_do;
         wready  <= ~w_got_ff & ~w_take & ~wr_do;
         if (aw_take) begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= awaddr;
         end else if (wr_do) begin
            aw_got_ff <= 1'b0;
         end
         if (w_take) begin
            w_got_ff  <= 1'b1;
            w_data_ff <= wdata;
            w_strb_ff <= wstrb;
         end else if (wr_do) begin
            w_got_ff <= 1'b0;
         end
         if (wr_do) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? RESP_OKAY : RESP_SLVER;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // axi4-lite read side
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb begin
      rd_mux = '0;
      rd_ok  = 1'b1;
      case (araddr)
         A_FLAGS:  rd_mux = {15'h0000, loaded_ff, wk_ff, cfg1_ff};
         A_STATUS: rd_mux = {28'h0000000, status_ff};
         A_MASK:   rd_mux = {28'h0000000, mask_ff};
         A_STATE:  rd_mux = {27'h0000000, irq, power_switch_control_pin,
                             pif.busy, wake_output_pin_oe, wake_output_pin_o};
         default:  rd_ok  = 1'b0;
      endcase
   end
   wire ar_take = arvalid & arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else begin
         arready <= ~rvalid & ~ar_take;
         if (ar_take) begin
            rvalid <= 1'b1;
            rdata  <= rd_mux;
            rresp  <= rd_ok ? RESP_OKAY : RESP_SLVER;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // busy run length helper
   logic [CNT_W-1:0] run_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_ff <= '0;
      end else begin
         run_ff <= pif.busy ? run_ff + 1'b1 : '0;
      end
   end
   wire [CNT_W-1:0] run_exp = pif.long_sel ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);

   sequence s_start;
      pif.start ##1 pif.busy;
   endsequence
   sequence s_hold;
      pif.busy [*2];
   endsequence

   a_role_value: assert property (
      ##1 second_indicator_role == $past(cfg1_ff[C1_ROLE] & cfg1_ff[C1_IND_LO + PIN2]))
      else $error("second indicator role wrong");
   a_role_gated: assert property (
      !cfg1_ff[C1_IND_LO + PIN2] |=> !second_indicator_role)
      else $error("role not gated by pin 2 select");
   a_ind_select: assert property (
      ##1 pin_indicator_select == $past(cfg1_ff[C1_IND_LO +: IND_W]))
      else $error("indicator select mismatch");
   a_sw_states: assert property (
      (!cfg1_ff[C1_SWSEL] && !deep_suspend_state && $stable(cfg1_ff))
      |=> power_switch_control_pin == !$past(cfg1_ff[C1_SWPOL]))
      else $error("switch asserted outside deep suspend");
   a_sw_polarity: assert property (
      (deep_suspend_state && $stable(cfg1_ff))
      |=> power_switch_control_pin == $past(cfg1_ff[C1_SWPOL]))
      else $error("switch polarity wrong");
   a_wake_off: assert property (
      (!wk_en && $stable(wk_ff)) |=> !wake_output_pin_oe && !act_ff)
      else $error("wake driven while disabled");
   a_pulse_once: assert property (
      s_start |-> s_hold ##0 !pif.start [*2])
      else $error("pulse restarted while busy");
   a_level_hold: assert property (
      (wk_en && !wk_form && (|status_ff) && $stable(wk_ff)) |=> act_ff)
      else $error("level wake not held");
   a_pulse_len: assert property (
      $fell(pif.busy) |-> run_ff == run_exp)
      else $error("wake pulse length wrong");
   a_drv_single: assert property (
      (wake_output_pin_oe && !wk_drv && $stable(wk_ff)) |-> wake_output_pin_o == wk_pol)
      else $error("single-sided drive level wrong");
   a_drv_push: assert property (
      (wk_en && wk_drv && $stable(wk_ff)) |=> wake_output_pin_oe)
      else $error("push-pull not driven");
   a_push_level: assert property (
      (wk_en && wk_drv && $stable(wk_ff)) |=> wake_output_pin_o == (act_ff ~^ wk_pol))
      else $error("wake level polarity wrong");
   a_class_net: assert property (
      (wk_class && link_up_evt == 1'b0 && !pin_evt) |-> !any_qual)
      else $error("network event passed link-up class");
   a_magic_gate: assert property (
      (!wk_ff[WK_MAGIC] && !(status_ff[ST_MAGIC])) |=> !status_ff[ST_MAGIC])
      else $error("magic wake while disabled");
   a_wr_resp: assert property (
      wr_do |=> bvalid ##0 !aw_got_ff ##0 !w_got_ff)
      else $error("write response late");
endmodule : pfw_top

/* dv/pfw_host_model.sv */
// Purpose: host side watching the wake output pin
// Assumes: bench picks the pull level that suits the driver type
// Notes: counts wake requests and the width of the last one
`timescale 1ns/1ps
module pfw_host_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   input  wire logic pull_up,
   input  wire logic active_high,
   output logic      level,
   output int        requests,
   output int        last_width
);
   logic act_ff;
   int   run_ff;
   wire  active = (level === active_high);
   // released pin falls to the pull level
   assign level = pin_oe ? pin_o : pull_up;
   always @(posedge aclk) begin
      if (!aresetn) begin
         act_ff     <= 1'b0;
         run_ff     <= 0;
         requests   <= 0;
         last_width <= 0;
      end else begin
         act_ff <= active;
         if (active) begin
            run_ff <= act_ff ? run_ff + 1 : 1;
         end
         if (active && !act_ff) begin
            requests <= requests + 1;
         end
         if (!active && act_ff) begin
            last_width <= run_ff;
         end
      end
   end
endmodule : pfw_host_model

/* dv/pfw_tb_top.sv */
// Purpose: self-checking bench for the pin function and wake block
// Assumes: flags reload only by reset, short counts 5 and 9
// Notes: host model resolves the wake wire
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module pfw_tb_top;
   import pfw_pkg::*;
   localparam int unsigned SC = 5;
   localparam int unsigned LC = 9;
   localparam logic [7:0]  CFG_TAB [5] = '{8'h00, 8'h80, 8'h93, 8'hAE, 8'h7D};
   logic aclk = 1'b0;
   logic aresetn, awvalid, wvalid, bready, arvalid, rready, flags_valid;
   logic awready, wready, bvalid, arready, rvalid, irq, role, pwr, wk_o, wk_oe;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [7:0]  cfg1_in, wake_flags_in;
   logic [4:0]  ind;
   logic light, deep, det, wpin, magic, da, link, host_pull, host_pol, host_level;
   int   requests, last_width;
   int   num_errors = 0;
   int   tests_run = 0;
   always #4 aclk = ~aclk;
   pfw_top #(.SHORT_CYC(SC), .LONG_CYC(LC)) pfw_top_i (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .flags_valid(flags_valid), .cfg1_in(cfg1_in),
      .wake_flags_in(wake_flags_in), .light_suspend_state(light),
      .deep_suspend_state(deep), .cable_detached(det), .wake_pin_in(wpin),
      .magic_pkt_evt(magic), .da_match_evt(da), .link_up_evt(link),
      .pin_indicator_select(ind), .second_indicator_role(role),
      .power_switch_control_pin(pwr), .wake_output_pin_o(wk_o),
      .wake_output_pin_oe(wk_oe), .irq(irq));
   pfw_host_model pfw_host_model_i (
      .aclk(aclk), .aresetn(aresetn), .pin_o(wk_o), .pin_oe(wk_oe), .pull_up(host_pull),
      .active_high(host_pol), .level(host_level), .requests(requests),
      .last_width(last_width));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic restart(input logic [7:0] c1, input logic [7:0] wf);
      aresetn       <= 1'b0;
      cfg1_in       <= c1;
      wake_flags_in <= wf;
      repeat (3) @(posedge aclk);
      aresetn     <= 1'b1;
      flags_valid <= 1'b1;
      @(posedge aclk);
      flags_valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : restart
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
   endtask : axi_write
   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask : axi_read
   task automatic fire(input int k, input int n);
      wpin  <= (k == 0);
      magic <= (k == 1);
      da    <= (k == 2);
      link  <= (k == 3);
      repeat (n) @(posedge aclk);
      {wpin, magic, da, link} <= 4'h0;
      repeat (7) @(posedge aclk);
   endtask : fire
   task automatic test_pins;
      logic [7:0] c;
      logic       on;
      for (int i = 0; i < 5; i++) begin
         c = CFG_TAB[i];
         restart(c, 8'h00);
         `CHK("indicator", c[6:2], ind)
         `CHK("role", c[7] & c[4], role)
         for (int s = 0; s < 4; s++) begin
            deep  <= (s == 1);
            light <= (s == 2);
            det   <= (s == 3);
            repeat (3) @(posedge aclk);
            on = (s == 1) || (c[1] && s > 1);
            `CHK("power pin", on ? c[0] : ~c[0], pwr)
         end
      end
      deep <= 1'b0;
      det  <= 1'b0;
   endtask : test_pins
   task automatic test_pulse;
      for (int l = 0; l < 2; l++) begin
         host_pull <= 1'b0;
         host_pol  <= 1'b1;
         restart(8'h00, l ? 8'hFA : 8'hDA);
         `CHK("pulse idle", 1'b0, host_level)
         fire(1, 3);
         repeat (LC + 4) @(posedge aclk);
         `CHK("pulse merge", 1, requests)
         `CHK("pulse width", l ? LC : SC, last_width)
         fire(1, 1);
         repeat (LC + 4) @(posedge aclk);
         `CHK("second pulse", 2, requests)
      end
   endtask : test_pulse
   task automatic test_level;
      logic [31:0] d;
      logic [1:0]  r;
      host_pull <= 1'b1;
      host_pol  <= 1'b0;
      restart(8'h00, 8'h83);
      `CHK("drain idle oe", 1'b0, wk_oe)
      axi_write(A_MASK, 32'hF, r);
      fire(2, 1);
      `CHK("drain active oe", 1'b1, wk_oe)
      `CHK("drain level", 1'b0, host_level)
      `CHK("irq set", 1'b1, irq)
      axi_read(A_STATUS, d, r);
      `CHK("status addr", 32'h4, d)
      axi_write(A_MASK, 32'h0, r);
      repeat (3) @(posedge aclk);
      `CHK("irq masked", 1'b0, irq)
      axi_write(A_STATUS, 32'h4, r);
      repeat (3) @(posedge aclk);
      `CHK("level cleared", 1'b1, host_level)
      host_pull <= 1'b0;
      host_pol  <= 1'b1;
      restart(8'h00, 8'h93);
      `CHK("source idle oe", 1'b0, wk_oe)
      fire(1, 1);
      `CHK("source drive", 2'b11, {wk_oe, wk_o})
      axi_read(A_STATE, d, r);
      `CHK("state word", 32'hB, d)
   endtask : test_level
   task automatic test_disabled;
      logic [31:0] d;
      logic [1:0]  r;
      restart(8'h00, 8'h7F);
      for (int k = 0; k < 4; k++) begin
         fire(k, k == 0 ? 4 : 1);
      end
      `CHK("off pin", 2'b00, {wk_oe, wk_o})
      axi_read(A_STATUS, d, r);
      `CHK("off status", 32'h0, d)
   endtask : test_disabled
   task automatic test_class;
      logic [31:0] d;
      logic [1:0]  r;
      restart(8'h00, 8'h9F);
      fire(1, 1);
      fire(2, 1);
      `CHK("link class idle", 2'b10, {wk_oe, wk_o})
      fire(3, 1);
      axi_read(A_STATUS, d, r);
      `CHK("link status", 32'h8, d)
      `CHK("push pull", 2'b11, {wk_oe, wk_o})
      restart(8'h00, 8'h9A);
      fire(3, 1);
      fire(2, 1);
      fire(1, 1);
      fire(0, 4);
      axi_read(A_STATUS, d, r);
      `CHK("net status", 32'h3, d)
   endtask : test_class
   task automatic test_regs;
      logic [31:0] d;
      logic [1:0]  r;
      restart(8'h93, 8'hDA);
      axi_read(A_MASK, d, r);
      `CHK("mask reset", 32'h0, d)
      cfg1_in       <= 8'h00;
      wake_flags_in <= 8'h00;
      flags_valid   <= 1'b1;
      @(posedge aclk);
      flags_valid <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_read(A_FLAGS, d, r);
      `CHK("flags held", 32'h0001DA93, d)
      `CHK("indicator held", 5'h04, ind)
      axi_write(A_MASK, 32'hA, r);
      `CHK("mask write resp", RESP_OKAY, r)
      axi_read(A_MASK, d, r);
      `CHK("mask back", 32'hA, d)
      axi_write(4'h2, 32'hF, r);
      `CHK("unmapped write", RESP_SLVER, r)
      axi_read(4'h2, d, r);
      `CHK("unmapped read", RESP_SLVER, r)
      `CHK("unmapped data", 32'h0, d)
   endtask : test_regs
   initial begin
      {awvalid, wvalid, arvalid, flags_valid} <= 4'h0;
      {light, deep, det, wpin, magic, da, link} <= 7'h00;
      {bready, rready, host_pull, host_pol} <= 4'hC;
      {awaddr, araddr, wstrb, wdata} <= {4'h0, 4'h0, 4'hF, 32'h0};
      test_pins();
      test_pulse();
      test_level();
      test_disabled();
      test_class();
      test_regs();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      $display("ERROR watchdog expected done seen hang");
      stop_test();
   end
endmodule : pfw_tb_top
